// File: design/shu_map.svh
`ifndef SHU_MAP_SVH
`define SHU_MAP_SVH

// ==========================================================
// Register bus map
`define SHU_ADDR_W          8
`define SHU_OFF_CTRL        8'h00
`define SHU_OFF_STATUS      8'h04
`define SHU_OFF_MASKS       8'h08

// ==========================================================
// Control register fields
`define SHU_CTRL_EVPEND     0
`define SHU_CTRL_DBGEN      1

// ==========================================================
// Special register selectors
`define SHU_SR_APPLICATION_STATUS_VIEW         5'h00
`define SHU_SR_IAPSR        5'h01
`define SHU_SR_EAPSR        5'h02
`define SHU_SR_PSR          5'h03
`define SHU_SR_EXCEPTION_NUMBER_VIEW         5'h05
`define SHU_SR_EXECUTION_STATUS_VIEW         5'h06
`define SHU_SR_IEPSR        5'h07
`define SHU_SR_PRIMARY_INTERRUPT_MASK      5'h10
`define SHU_SR_BASE_PRIORITY_MASK      5'h11
`define SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK  5'h12
`define SHU_SR_FAULT_MASK_A    5'h13

// ==========================================================
// Status word field positions
`define SHU_PSR_FLAGS_LSB   27
`define SHU_PSR_GE_LSB      16
`define SHU_PRIO_W          8

// ==========================================================
// Reset values
`define SHU_RST_EVENT       1'b0
`define SHU_RST_CTRL        2'h0

`endif

// File: design/shu_pkg.sv
`default_nettype none

// ==========================================================
// Types shared by the unit and its neighbours
package shu_pkg;
  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_DSB = 3'h1,
    MODE_WFE = 3'h4,
    MODE_WFI = 3'h2
  } shu_mode_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_DMB, OP_DSB, OP_ISB, OP_MRS, OP_MSR,
    OP_NOP, OP_SEV, OP_SVC, OP_WFE, OP_WFI
  } shu_op_t;

  typedef struct packed {
    logic        valid;
    shu_op_t     op;
    logic [4:0]  sreg;
    logic [1:0]  msrMask;   // Bit1 flags, bit0 greater-equal bits
    logic [31:0] srcValue;
  } shu_instr_t;

  typedef struct packed {
    logic excPendUnmasked;
    logic excNewPending;
    logic irqPendUnmasked;
    logic irqPendAny;
  } shu_nvic_t;

  typedef struct packed {
    logic valid;
    logic needPriv;
  } shu_ppb_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } shu_bus_t;

  typedef struct packed {
    shu_mode_t   mode;
    logic        dmbDrain;
    logic        eventReg;
    logic [4:0]  flags;
    logic [3:0]  ge;
    logic        primary_interrupt_mask;
    logic        fault_mask_a;
    logic [7:0]  base_priority_mask;
    logic        event_on_pending_enable;
    logic        debugEn;
    logic        evtSync1;
    logic        evtSync2;
    logic        evtSync3;
    logic        dbgSync1;
    logic        dbgSync2;
    logic        issueHold;
    logic        memHold;
    logic        flushPipe;
    logic        eventOut;
    logic        svcRaise;
    logic        instrDone;
    logic        mrsValid;
    logic [31:0] mrsData;
    logic        flagsUpd;
    logic        ppbFault;
    logic        irqBlock;
    logic        faultBlock;
    logic        sleeping;
    logic [31:0] rdata;
  } shu_state_t;
endpackage

`default_nettype wire

// File: design/shu_unit.sv
// Chosen here: the register addresses and the strobed register port.
`include "shu_map.svh"
`default_nettype none

// What this block does
// RULE1 - Memory before data barrier completes first
// RULE2 - Data barrier leaves non-memory instructions alone
// RULE3 - Hold issue after sync barrier until done
// RULE4 - Sync barrier done when accesses drained
// RULE5 - Instruction barrier flushes and refetches
// RULE6 - Status reads return zero state fields
// RULE7 - Conditional max name reads base mask
// RULE8 - Software avoids SP/PC as read target
// RULE9 - Software avoids SP/PC as write source
// RULE10 - Unprivileged moves reach only application status
// RULE11 - Unprivileged writes skip reserved and state bits
// RULE12 - Conditional max writes only when lowering
// RULE13 - Application status write sets flags directly
// RULE14 - Listed instructions leave flags unchanged
// RULE15 - No-operation retires with no cost
// RULE16 - Send event pulses out, sets event
// RULE17 - Supervisor call raises exception, immediate ignored
// RULE18 - Wait-for-event sleeps until wake source
// RULE19 - New pending exception wakes when enabled
// RULE20 - Event set: clear it, continue
// RULE21 - Wait-for-interrupt sleeps until interrupt cause
// RULE22 - Unprivileged private region access faults
// RULE23 - Masks block interrupts and faults
// RULE24 - Event register clears at reset
module shu_unit (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire shu_pkg::shu_instr_t instr,
  input  wire logic               privileged,
  input  wire logic               memBusy,
  input  wire shu_pkg::shu_nvic_t nvic,
  input  wire shu_pkg::shu_ppb_t  ppbReq,
  input  wire logic               extEventPin,
  input  wire logic               debugReqPin,
  input  wire shu_pkg::shu_bus_t  bus,
  output logic [31:0]             busRdata,
  output logic                    issueHold,
  output logic                    memHold,
  output logic                    flushPipe,
  output logic                    eventOut,
  output logic                    svcRaise,
  output logic                    instrDone,
  output logic                    mrsValid,
  output logic [31:0]             mrsData,
  output logic                    flagsUpd,
  output logic [4:0]              flagsOut,
  output logic                    ppbFault,
  output logic                    irqBlock,
  output logic                    faultBlock,
  output logic                    sleeping
);
  import shu_pkg::*;

  // ==========================================================
  // State and helpers
  shu_state_t state_q;
  shu_state_t state_d;
  logic       take;
  logic       evtSet;
  logic       wakeWfe;
  logic       wakeWfi;
  logic       bpUpdate;

  // Status view with only flag and greater-equal fields populated
  function automatic logic [31:0] psrView(input logic [4:0] f, input logic [3:0] g);
    logic [31:0] v;
    v = 32'h0;
    v[`SHU_PSR_FLAGS_LSB +: 5] = f;
    v[`SHU_PSR_GE_LSB +: 4] = g;
    return v;
  endfunction

  // Selector names one of the program status views
  function automatic logic isPsr(input logic [4:0] s);
    return (s == `SHU_SR_APPLICATION_STATUS_VIEW) || (s == `SHU_SR_IAPSR) || (s == `SHU_SR_EAPSR) ||
           (s == `SHU_SR_PSR) || (s == `SHU_SR_EXCEPTION_NUMBER_VIEW) || (s == `SHU_SR_EXECUTION_STATUS_VIEW) ||
           (s == `SHU_SR_IEPSR);
  endfunction

  // ==========================================================
  // Issue, wake, event and mask-lowering terms
  assign take    = instr.valid && !state_q.issueHold;
  assign evtSet  = (take && instr.op == OP_SEV) ||
                   (state_q.evtSync2 && !state_q.evtSync3);
  assign wakeWfe = nvic.excPendUnmasked ||
                   (state_q.event_on_pending_enable && nvic.excNewPending) ||   // [RULE19]
                   (state_q.dbgSync2 && state_q.debugEn) ||
                   (state_q.evtSync2 && !state_q.evtSync3);       // [RULE18]
  assign wakeWfi = nvic.irqPendUnmasked ||
                   (state_q.primary_interrupt_mask && nvic.irqPendAny) ||
                   state_q.dbgSync2;                              // [RULE21]
  assign bpUpdate = (instr.srcValue[7:0] != 8'h0) &&
                    ((state_q.base_priority_mask == 8'h0) ||
                     (instr.srcValue[7:0] < state_q.base_priority_mask));    // [RULE12]

  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    state_d.flushPipe = 1'b0;
    state_d.eventOut  = 1'b0;
    state_d.svcRaise  = 1'b0;
    state_d.instrDone = 1'b0;
    state_d.mrsValid  = 1'b0;
    state_d.flagsUpd  = 1'b0;
    state_d.rdata     = 32'h0;
    state_d.ppbFault  = ppbReq.valid && ppbReq.needPriv && !privileged;  // [RULE22]

    // Pin synchronisers and event edge
    state_d.evtSync1 = extEventPin;
    state_d.evtSync2 = state_q.evtSync1;
    state_d.evtSync3 = state_q.evtSync2;
    state_d.dbgSync1 = debugReqPin;
    state_d.dbgSync2 = state_q.dbgSync1;

    // Data barrier drain ends once nothing is outstanding
    if (state_q.dmbDrain && !memBusy) begin
      state_d.dmbDrain = 1'b0;  // [RULE1]
    end

    // Barrier and sleep sequencing
    case (state_q.mode)
      MODE_RUN: begin
        if (take) begin
          state_d.instrDone = 1'b1;
          case (instr.op)
            OP_DMB: begin
              state_d.dmbDrain = memBusy;  // [RULE1] [RULE2]
            end
            OP_DSB: begin
              state_d.mode = MODE_DSB;  // [RULE3]
              state_d.instrDone = 1'b0;
            end
            OP_ISB: begin
              state_d.flushPipe = 1'b1;  // [RULE5]
            end
            OP_SEV: begin
              state_d.eventOut = 1'b1;  // [RULE16]
            end
            OP_SVC: begin
              state_d.svcRaise = 1'b1;  // [RULE17]
            end
            OP_WFE: begin
              if (!state_q.eventReg) begin
                state_d.mode = MODE_WFE;  // [RULE18]
                state_d.instrDone = 1'b0;
              end
            end
            OP_WFI: begin
              state_d.mode = MODE_WFI;  // [RULE21]
              state_d.instrDone = 1'b0;
            end
            default: begin
              state_d.mode = MODE_RUN;  // [RULE15]
            end
          endcase
        end
      end
      MODE_DSB: begin
        if (!memBusy && !state_q.dmbDrain) begin
          state_d.mode = MODE_RUN;  // [RULE4]
          state_d.instrDone = 1'b1;
        end
      end
      MODE_WFE: begin
        if (wakeWfe) begin
          state_d.mode = MODE_RUN;
          state_d.instrDone = 1'b1;
        end
      end
      MODE_WFI: begin
        if (wakeWfi) begin
          state_d.mode = MODE_RUN;
          state_d.instrDone = 1'b1;
        end
      end
      default: begin
        state_d.mode = MODE_RUN;
      end
    endcase

    // Event register: clear on consumed wait, set wins
    if (take && instr.op == OP_WFE && state_q.eventReg) begin
      state_d.eventReg = 1'b0;  // [RULE20]
    end
    if (state_q.mode == MODE_WFE && wakeWfe) begin
      state_d.eventReg = 1'b0;
    end
    if (evtSet) begin
      state_d.eventReg = 1'b1;  // [RULE16]
    end

    // Special register read
    if (take && instr.op == OP_MRS) begin
      state_d.mrsValid = 1'b1;
      state_d.mrsData  = 32'h0;
      if (isPsr(instr.sreg)) begin
        // Exception-number and state-only views always read as zero
        if (instr.sreg <= `SHU_SR_PSR) begin
          state_d.mrsData = psrView(state_q.flags, state_q.ge);  // [RULE6]
        end
      end else if (privileged) begin  // [RULE10]
        case (instr.sreg)
          `SHU_SR_PRIMARY_INTERRUPT_MASK:     state_d.mrsData = {31'h0, state_q.primary_interrupt_mask};
          `SHU_SR_FAULT_MASK_A:   state_d.mrsData = {31'h0, state_q.fault_mask_a};
          `SHU_SR_BASE_PRIORITY_MASK,
          `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK: state_d.mrsData = {24'h0, state_q.base_priority_mask};  // [RULE7]
          default:             state_d.mrsData = 32'h0;
        endcase
      end
    end

    // Special register write
    if (take && instr.op == OP_MSR) begin
      if (instr.sreg == `SHU_SR_APPLICATION_STATUS_VIEW) begin
        // Only flag and greater-equal bits are ever taken
        if (instr.msrMask[1]) begin
          state_d.flags = instr.srcValue[`SHU_PSR_FLAGS_LSB +: 5];  // [RULE13] [RULE11]
        end
        if (instr.msrMask[0]) begin
          state_d.ge = instr.srcValue[`SHU_PSR_GE_LSB +: 4];  // [RULE13]
        end
        state_d.flagsUpd = instr.msrMask[1];  // [RULE14]
      end else if (privileged) begin  // [RULE10]
        case (instr.sreg)
          `SHU_SR_PRIMARY_INTERRUPT_MASK:   state_d.primary_interrupt_mask = instr.srcValue[0];
          `SHU_SR_FAULT_MASK_A: state_d.fault_mask_a = instr.srcValue[0];
          `SHU_SR_BASE_PRIORITY_MASK:   state_d.base_priority_mask = instr.srcValue[7:0];
          `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK: begin
            if (bpUpdate) begin
              state_d.base_priority_mask = instr.srcValue[7:0];  // [RULE12]
            end
          end
          default: state_d.base_priority_mask = state_q.base_priority_mask;
        endcase
      end
    end

    // Register bus
    if (bus.wr && bus.addr == `SHU_OFF_CTRL) begin
      state_d.event_on_pending_enable = bus.wdata[`SHU_CTRL_EVPEND];
      state_d.debugEn   = bus.wdata[`SHU_CTRL_DBGEN];
    end
    if (bus.rd) begin
      case (bus.addr)
        `SHU_OFF_CTRL:   state_d.rdata = {30'h0, state_q.debugEn, state_q.event_on_pending_enable};
        `SHU_OFF_STATUS: state_d.rdata = {26'h0, state_q.mode, state_q.sleeping,
                                          state_q.dmbDrain, state_q.eventReg};
        `SHU_OFF_MASKS:  state_d.rdata = {22'h0, state_q.fault_mask_a, state_q.primary_interrupt_mask,
                                          state_q.base_priority_mask};
        default:         state_d.rdata = 32'h0;
      endcase
    end

    // Registered holds and masks
    state_d.issueHold  = (state_d.mode != MODE_RUN);  // [RULE3]
    state_d.memHold    = state_d.dmbDrain;  // [RULE1]
    state_d.sleeping   = (state_d.mode == MODE_WFE) || (state_d.mode == MODE_WFI);
    state_d.irqBlock   = state_d.primary_interrupt_mask || state_d.fault_mask_a;  // [RULE23]
    state_d.faultBlock = state_d.fault_mask_a;  // [RULE23]
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
      state_q.mode <= MODE_RUN;
      state_q.eventReg <= `SHU_RST_EVENT;  // [RULE24]
      {state_q.debugEn, state_q.event_on_pending_enable} <= `SHU_RST_CTRL;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  assign busRdata   = state_q.rdata;
  assign issueHold  = state_q.issueHold;
  assign memHold    = state_q.memHold;
  assign flushPipe  = state_q.flushPipe;
  assign eventOut   = state_q.eventOut;
  assign svcRaise   = state_q.svcRaise;
  assign instrDone  = state_q.instrDone;
  assign mrsValid   = state_q.mrsValid;
  assign mrsData    = state_q.mrsData;
  assign flagsUpd   = state_q.flagsUpd;
  assign flagsOut   = state_q.flags;
  assign ppbFault   = state_q.ppbFault;
  assign irqBlock   = state_q.irqBlock;
  assign faultBlock = state_q.faultBlock;
  assign sleeping   = state_q.sleeping;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_isb_taken;
    state_q.mode == MODE_RUN && take && instr.op == OP_ISB;
  endsequence
  sequence s_flush_pulse;
    flushPipe ##1 (!flushPipe || $past(take && instr.op == OP_ISB));
  endsequence

  a_dmb_mem_hold: assert property (  // [RULE1]
    take && instr.op == OP_DMB && memBusy |=> memHold) else $error("data barrier no hold");
  a_dmb_free_issue: assert property (  // [RULE2]
    state_q.mode == MODE_RUN && take && instr.op == OP_DMB |=> !issueHold)
    else $error("data barrier stalled issue");
  a_dsb_hold: assert property (  // [RULE3]
    state_q.mode == MODE_RUN && take && instr.op == OP_DSB |=> issueHold && !instrDone)
    else $error("sync barrier no hold");
  a_dsb_wait_mem: assert property (  // [RULE4]
    state_q.mode == MODE_DSB && memBusy |=> issueHold) else $error("sync barrier early");
  a_dsb_release: assert property (  // [RULE4]
    state_q.mode == MODE_DSB && !memBusy && !state_q.dmbDrain |=> !issueHold && instrDone)
    else $error("sync barrier stuck");
  a_isb_flush_once: assert property (  // [RULE5]
    s_isb_taken |=> s_flush_pulse) else $error("no flush pulse");
  a_mrs_zero_state: assert property (  // [RULE6]
    mrsValid |-> mrsData[26:20] == 7'h0 && mrsData[15:9] == 7'h0)
    else $error("state fields not zero");
  a_bpmax_read: assert property (  // [RULE7]
    state_q.mode == MODE_RUN && take && privileged && instr.op == OP_MRS &&
    instr.sreg == `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK |=> mrsData[7:0] == $past(state_q.base_priority_mask))
    else $error("conditional max read differs");
  a_unpriv_masks: assert property (  // [RULE10]
    take && !privileged && instr.op == OP_MSR |=> $stable({state_q.primary_interrupt_mask,
    state_q.fault_mask_a, state_q.base_priority_mask})) else $error("unprivileged mask write");
  a_bpmax_zero_src: assert property (  // [RULE12]
    take && instr.op == OP_MSR && instr.sreg == `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK &&
    instr.srcValue[7:0] == 8'h0 |=> $stable(state_q.base_priority_mask)) else $error("zero lowered mask");
  a_flags_stable: assert property (  // [RULE14]
    !(take && instr.op == OP_MSR && instr.sreg == `SHU_SR_APPLICATION_STATUS_VIEW) |=> $stable(flagsOut))
    else $error("flags changed");
  a_sev_sets: assert property (  // [RULE16]
    state_q.mode == MODE_RUN && take && instr.op == OP_SEV |=> eventOut && state_q.eventReg)
    else $error("send event lost");
  a_wfe_skip: assert property (  // [RULE20]
    state_q.mode == MODE_RUN && take && instr.op == OP_WFE && state_q.eventReg && !evtSet
    |=> !state_q.eventReg && !sleeping && instrDone) else $error("wait did not continue");
  a_wfe_sleep: assert property (  // [RULE18]
    state_q.mode == MODE_RUN && take && instr.op == OP_WFE && !state_q.eventReg
    |=> sleeping) else $error("wait did not sleep");
  a_ppb_fault: assert property (  // [RULE22]
    ppbReq.valid && ppbReq.needPriv && !privileged |=> ppbFault) else $error("no bus fault");

  // Sleeping waits: stay asleep until a wake term, then retire at once
  sequence s_wfe_woken;
    state_q.mode == MODE_WFE && wakeWfe;
  endsequence
  sequence s_wake_retire;
    instrDone && !sleeping && !issueHold;
  endsequence

  a_wfe_wake: assert property (  // [RULE18]
    s_wfe_woken |=> s_wake_retire) else $error("wait for event did not wake");
  a_wfe_pend_wake: assert property (  // [RULE19]
    state_q.mode == MODE_WFE && state_q.event_on_pending_enable && nvic.excNewPending |=> s_wake_retire)
    else $error("new pending did not wake");
  a_wfe_stay: assert property (  // [RULE18]
    state_q.mode == MODE_WFE && !wakeWfe |=> sleeping && issueHold && !instrDone)
    else $error("wait for event woke early");
  a_wfi_wake: assert property (  // [RULE21]
    state_q.mode == MODE_WFI && wakeWfi |=> s_wake_retire)
    else $error("wait for interrupt did not wake");
  a_wfi_stay: assert property (  // [RULE21]
    state_q.mode == MODE_WFI && !wakeWfi |=> sleeping && issueHold && !instrDone)
    else $error("wait for interrupt woke early");
  a_ext_event_set: assert property (  // [RULE18]
    state_q.evtSync2 && !state_q.evtSync3 |=> state_q.eventReg)
    else $error("peripheral event not latched");
  a_svc_raise: assert property (  // [RULE17]
    take && instr.op == OP_SVC |=> svcRaise && instrDone) else $error("no supervisor call");
  a_application_status_view_write: assert property (  // [RULE13]
    take && instr.op == OP_MSR && instr.sreg == `SHU_SR_APPLICATION_STATUS_VIEW && instr.msrMask[1]
    |=> flagsUpd && flagsOut == $past(instr.srcValue[`SHU_PSR_FLAGS_LSB +: 5]))
    else $error("flags not written");
  a_mrs_view_zero: assert property (  // [RULE6]
    take && instr.op == OP_MRS &&
    instr.sreg inside {`SHU_SR_EXCEPTION_NUMBER_VIEW, `SHU_SR_EXECUTION_STATUS_VIEW, `SHU_SR_IEPSR} |=> mrsData == 32'h0)
    else $error("state view not zero");
  a_dmb_drain_end: assert property (  // [RULE1]
    memHold && !memBusy |=> !memHold) else $error("data barrier hold stuck");
  a_mask_block: assert property (  // [RULE23]
    irqBlock == (state_q.primary_interrupt_mask || state_q.fault_mask_a) && faultBlock == state_q.fault_mask_a)
    else $error("mask block wrong");
endmodule

`default_nettype wire

// File: bench/tb_system_hint_barrier_unit.sv
`include "shu_map.svh"
`default_nettype none

module tb_system_hint_barrier_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import shu_pkg::*;

  // ==========================================================
  // Stimulus, observed outputs and counters
  logic        sys_clk     = 1'b0;
  logic        reset       = 1'b1;
  shu_instr_t  instr       = '0;
  logic        privileged  = 1'b1;
  logic        memBusy     = 1'b0;
  shu_nvic_t   nvic        = '0;
  shu_ppb_t    ppbReq      = '0;
  logic        extEventPin = 1'b0;
  logic        debugReqPin = 1'b0;
  shu_bus_t    bus         = '0;
  logic [31:0] busRdata;
  logic        issueHold, memHold, flushPipe, eventOut, svcRaise, instrDone;
  logic        mrsValid, flagsUpd, ppbFault, irqBlock, faultBlock, sleeping;
  logic [31:0] mrsData;
  logic [4:0]  flagsOut;
  logic [4:0]  expFlags    = 5'h00;
  logic [31:0] mrsGot;
  int          errCount    = 0;
  int          checks      = 0;

  // Pulse vector bits seen one cycle after an instruction is taken
  localparam logic [7:0] P_DONE = 8'h80, P_MRS = 8'h40, P_FLUSH = 8'h20, P_EVT = 8'h10;
  localparam logic [7:0] P_SVC  = 8'h08, P_FLG = 8'h04, P_HOLD  = 8'h02, P_SLP = 8'h01;

  shu_unit dut (
    .sys_clk, .reset, .instr, .privileged, .memBusy, .nvic, .ppbReq, .extEventPin,
    .debugReqPin, .bus, .busRdata, .issueHold, .memHold, .flushPipe, .eventOut,
    .svcRaise, .instrDone, .mrsValid, .mrsData, .flagsUpd, .flagsOut, .ppbFault,
    .irqBlock, .faultBlock, .sleeping
  );

  // Clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  // ==========================================================
  // Compare, access and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One instruction, then its pulses and the expected flags
  // The port carries no register numbers, so SP and PC are never named
  task automatic issue(input shu_op_t op, input logic [4:0] sr, input logic [1:0] mk,
                       input logic [31:0] v, input logic [7:0] expPulse);
    @(posedge sys_clk);
    instr <= {1'b1, op, sr, mk, v};
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    #1;
    chk({24'h0, instrDone, mrsValid, flushPipe, eventOut, svcRaise, flagsUpd, issueHold,
         sleeping}, {24'h0, expPulse});
    chk({27'h0, flagsOut}, {27'h0, expFlags});
    mrsGot = mrsData;
  endtask

  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk(busRdata, exp);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic private_peripheral_region(input logic need, input logic exp);
    @(posedge sys_clk);
    ppbReq <= {1'b1, need};
    @(posedge sys_clk);
    ppbReq.valid <= 1'b0;
    #1;
    chk({31'h0, ppbFault}, {31'h0, exp});
  endtask

  task automatic pulsePend();
    @(posedge sys_clk);
    nvic.excNewPending <= 1'b1;
    @(posedge sys_clk);
    nvic.excNewPending <= 1'b0;
    #1;
  endtask

  // Bounded wait for a sleeping or held instruction to retire
  task automatic waitDone();
    int n;
    n = 0;
    while (instrDone !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({31'h0, instrDone}, 32'h1);
    chk({30'h0, issueHold, sleeping}, 32'h0);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    errCount++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [4:0]  selTab [6] = '{`SHU_SR_PSR, `SHU_SR_IAPSR, `SHU_SR_EAPSR,
                                `SHU_SR_EXCEPTION_NUMBER_VIEW, `SHU_SR_EXECUTION_STATUS_VIEW, `SHU_SR_IEPSR};
    logic [4:0]  bpSel  [6] = '{`SHU_SR_BASE_PRIORITY_MASK, `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK, `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK,
                                `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK, `SHU_SR_BASE_PRIORITY_MASK, `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK};
    logic [7:0]  bpVal  [6] = '{8'h40, 8'h80, 8'h00, 8'h20, 8'h00, 8'h60};
    logic [7:0]  bpExp  [6] = '{8'h40, 8'h40, 8'h40, 8'h20, 8'h00, 8'h60};
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rdReg(8'h04, 32'h0);
    rdReg(8'h08, 32'h0);
    rdReg(8'h0c, 32'h0);
    // First wait after reset sleeps; a new pending only wakes once enabled
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    rdReg(8'h04, {26'h0, MODE_WFE, 3'h4});
    pulsePend();
    chk({31'h0, sleeping}, 32'h1);
    wrReg(8'h00, 32'h1);
    rdReg(8'h00, 32'h1);
    pulsePend();
    waitDone();
    rdReg(8'h04, 32'h0);
    issue(OP_SEV, 5'h0, 2'h0, 32'h0, P_DONE | P_EVT);
    rdReg(8'h04, 32'h1);
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_DONE);
    rdReg(8'h04, 32'h0);
    issue(OP_ISB, 5'h0, 2'h0, 32'h0, P_DONE | P_FLUSH);
    issue(OP_SVC, 5'h0, 2'h0, 32'h0000_00ff, P_DONE | P_SVC);
    // Barriers while an access is outstanding
    @(posedge sys_clk);
    memBusy <= 1'b1;
    issue(OP_DMB, 5'h0, 2'h0, 32'h0, P_DONE);
    chk({31'h0, memHold}, 32'h1);
    rdReg(8'h04, 32'h2);
    issue(OP_NOP, 5'h0, 2'h0, 32'h0, P_DONE);
    issue(OP_DSB, 5'h0, 2'h0, 32'h0, P_HOLD);
    repeat (4) @(posedge sys_clk);
    #1;
    chk({30'h0, memHold, issueHold}, 32'h3);
    @(posedge sys_clk);
    memBusy <= 1'b0;
    waitDone();
    chk({31'h0, memHold}, 32'h0);
    // Status moves
    expFlags = 5'h15;
    issue(OP_MSR, `SHU_SR_APPLICATION_STATUS_VIEW, 2'h3, 32'ha80f_1234, P_DONE | P_FLG);
    for (int i = 0; i < 6; i++) begin
      issue(OP_MRS, selTab[i], 2'h0, 32'h0, P_DONE | P_MRS);
      chk(mrsGot, (i < 3) ? 32'ha80f_0000 : 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      issue(OP_MSR, bpSel[i], 2'h0, {24'h0, bpVal[i]}, P_DONE);
      issue(OP_MRS, `SHU_SR_CONDITIONAL_MAX_PRIORITY_MASK, 2'h0, 32'h0, P_DONE | P_MRS);
      chk(mrsGot, {24'h0, bpExp[i]});
    end
    // Unprivileged moves and private region access
    @(posedge sys_clk);
    privileged <= 1'b0;
    issue(OP_MSR, `SHU_SR_BASE_PRIORITY_MASK, 2'h0, 32'h10, P_DONE);
    issue(OP_MRS, `SHU_SR_BASE_PRIORITY_MASK, 2'h0, 32'h0, P_DONE | P_MRS);
    chk(mrsGot, 32'h0);
    expFlags = 5'h01;
    issue(OP_MSR, `SHU_SR_APPLICATION_STATUS_VIEW, 2'h2, 32'h0f00_ffff, P_DONE | P_FLG);
    private_peripheral_region(1'b1, 1'b1);
    private_peripheral_region(1'b0, 1'b0);
    @(posedge sys_clk);
    privileged <= 1'b1;
    private_peripheral_region(1'b1, 1'b0);
    issue(OP_MRS, `SHU_SR_PSR, 2'h0, 32'h0, P_DONE | P_MRS);
    chk(mrsGot, 32'h080f_0000);
    rdReg(8'h08, 32'h60);
    // Masks and interrupt waits
    issue(OP_MSR, `SHU_SR_PRIMARY_INTERRUPT_MASK, 2'h0, 32'h1, P_DONE);
    chk({30'h0, irqBlock, faultBlock}, 32'h2);
    issue(OP_WFI, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    nvic.irqPendAny <= 1'b1;
    waitDone();
    nvic.irqPendAny <= 1'b0;
    issue(OP_MSR, `SHU_SR_FAULT_MASK_A, 2'h0, 32'h1, P_DONE);
    chk({30'h0, irqBlock, faultBlock}, 32'h3);
    rdReg(8'h08, 32'h360);
    issue(OP_MSR, `SHU_SR_PRIMARY_INTERRUPT_MASK, 2'h0, 32'h0, P_DONE);
    issue(OP_MSR, `SHU_SR_FAULT_MASK_A, 2'h0, 32'h0, P_DONE);
    chk({30'h0, irqBlock, faultBlock}, 32'h0);
    issue(OP_WFI, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    nvic.irqPendUnmasked <= 1'b1;
    waitDone();
    nvic.irqPendUnmasked <= 1'b0;
    issue(OP_WFI, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    debugReqPin <= 1'b1;
    waitDone();
    debugReqPin <= 1'b0;
    // Event waits: peripheral edge, unmasked exception, debug once enabled
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    extEventPin <= 1'b1;
    waitDone();
    extEventPin <= 1'b0;
    rdReg(8'h04, 32'h1);
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_DONE);
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    nvic.excPendUnmasked <= 1'b1;
    waitDone();
    nvic.excPendUnmasked <= 1'b0;
    wrReg(8'h00, 32'h2);
    issue(OP_WFE, 5'h0, 2'h0, 32'h0, P_HOLD | P_SLP);
    @(posedge sys_clk);
    debugReqPin <= 1'b1;
    waitDone();
    debugReqPin <= 1'b0;
    tally_and_finish();
  end
endmodule

`default_nettype wire
